// >>> bench/mem_io_bus_model.sv
/* memory and I/O bus end: latches each strobed address cycle
   assumes the generator's one-cycle valid strobe */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus model
module mem_io_bus_model (
   // clock and address cycle
   input  wire logic        i_sys_clk,
   input  wire logic        i_valid,
   input  wire logic        i_io,
   input  wire logic [19:0] i_addr,
   // last cycle taken
   output var logic [19:0]  o_last,
   output var logic         o_last_io
);
   // takes only strobed cycles, so a stuck address between them is not seen
   always @(posedge i_sys_clk) begin
      if (i_valid) begin
         o_last <= i_addr;
         o_last_io <= i_io;
      end
   end
endmodule : mem_io_bus_model
`default_nettype wire

// >>> bench/seg_addr_gen_monitor.sv
/* checker for the address generator: segment choice, wrap, I/O form
   assumes a bind onto seg_addr_gen with matching port names */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// monitor
module seg_addr_gen_monitor
   import seg_addr_pkg::*;
(
   // clock and reset
   input wire logic                     i_sys_clk,
   input wire logic                     i_sys_rst,
   // request side
   input wire logic                     i_req,
   input wire seg_addr_pkg::ref_kind_t  i_ref_kind,
   input wire logic [15:0]              i_offset,
   input wire logic [7:0]               i_port_imm,
   input wire logic                     i_io_word,
   // bus side and registers
   input wire logic [19:0]              o_addr,
   input wire logic                     o_addr_valid,
   input wire logic                     o_io_cycle,
   input wire logic                     o_io_word,
   input wire logic [15:0]              o_code_segment,
   input wire logic [15:0]              o_data_segment_register,
   input wire logic [15:0]              o_stack_segment,
   input wire logic [15:0]              o_extra_segment_register,
   input wire logic [15:0]              o_port_pointer_register
);
   // sum kept at 20 bits so a carry out of bit 19 is lost
   function automatic logic [19:0] pa(input logic [15:0] s, input logic [15:0] o);
      return {s, 4'h0} + {4'h0, o};
   endfunction : pa
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   a_valid_pulse: assert property (i_req |=> o_addr_valid)
      else $error("no valid after request");
   a_fetch_code: assert property (i_req && i_ref_kind == REF_FETCH |=>
      o_addr == pa($past(o_code_segment), $past(i_offset)) && !o_io_cycle)
      else $error("fetch address wrong");
   a_data_seg: assert property (i_req && i_ref_kind inside {REF_DATA, REF_STR_SRC} |=>
      o_addr == pa($past(o_data_segment_register), $past(i_offset)))
      else $error("data address wrong");
   a_stack_seg: assert property (i_req && i_ref_kind inside {REF_STACK, REF_BASE_PTR} |=>
      o_addr == pa($past(o_stack_segment), $past(i_offset)))
      else $error("stack address wrong");
   a_extra_seg: assert property (i_req && i_ref_kind == REF_STR_DEST |=>
      o_addr == pa($past(o_extra_segment_register), $past(i_offset)))
      else $error("string dest address wrong");
   a_io_imm_zext: assert property (i_req && i_ref_kind == REF_IO_IMM |=>
      o_addr == {12'h000, $past(i_port_imm)} && o_io_cycle)
      else $error("immediate port wrong");
   a_io_ptr_port: assert property (i_req && i_ref_kind == REF_IO_PTR |=>
      o_addr == {4'h0, $past(o_port_pointer_register)} && o_io_cycle)
      else $error("pointer port wrong");
   a_idle_hold: assert property (!i_req |=> !o_addr_valid && $stable(o_addr))
      else $error("idle cycle disturbed address");
   a_io_word_copy: assert property (i_req && i_ref_kind inside {REF_IO_IMM, REF_IO_PTR} |=>
      o_io_word == $past(i_io_word))
      else $error("io word flag wrong");
   a_mem_not_io: assert property (i_req && !(i_ref_kind inside {REF_IO_IMM, REF_IO_PTR}) |=>
      !o_io_cycle && !o_io_word)
      else $error("memory cycle flagged as io");
endmodule : seg_addr_gen_monitor
`default_nettype wire

// >>> bench/segmented_address_generator_bench.sv
/* bench for seg_addr_gen: reset values, segment choice, wrap, I/O ports
   assumes monitor and bus model compiled before this file */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module segmented_address_generator_bench;
   import seg_addr_pkg::*;
   logic clk = 0, rst = 1, sl = 0, pl = 0, req = 0, iow = 0;
   logic [1:0] sel = 0;
   logic [15:0] sv = 0, ofs = 0, cs, ds, ss, es, pp;
   logic [7:0] imm = 0;
   ref_kind_t kind = REF_FETCH;
   logic [19:0] addr, last;
   logic vld, ioc, last_io, iow_q;
   int bad_count = 0, n_checks = 0;
   always #12.5 clk = ~clk;
   seg_addr_gen dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_seg_load(sl), .i_seg_sel(sel),
      .i_seg_value(sv), .i_port_ptr_load(pl), .i_port_ptr_value(sv), .i_req(req),
      .i_ref_kind(kind), .i_offset(ofs), .i_port_imm(imm), .i_io_word(iow), .o_addr(addr),
      .o_addr_valid(vld), .o_io_cycle(ioc), .o_io_word(iow_q), .o_code_segment(cs),
      .o_data_segment_register(ds), .o_stack_segment(ss), .o_extra_segment_register(es),
      .o_port_pointer_register(pp));
   mem_io_bus_model bus_u (.i_sys_clk(clk), .i_valid(vld), .i_io(ioc), .i_addr(addr),
      .o_last(last), .o_last_io(last_io));
   // compare and count
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // one-cycle load; port pointer shares the value bus
   task automatic ld(input logic [1:0] s, input logic [15:0] v, input logic port);
      @(posedge clk) #1;
      sel = s;
      sv = v;
      sl = !port;
      pl = port;
      @(posedge clk) #1;
      sl = 0;
      pl = 0;
   endtask : ld
   // one request; valid due one cycle on, bus sees it the next
   task automatic go(input ref_kind_t k, input logic [15:0] o, input logic [19:0] exp);
      @(posedge clk) #1;
      kind = k;
      ofs = o;
      req = 1;
      @(posedge clk) #1;
      req = 0;
      chk({19'h0_0000, vld}, 20'h0_0001);
      @(posedge clk) #1;
      chk(last, exp);
   endtask : go
   // segment kinds: each table entry is the segment the kind must pick
   task automatic t_segments();
      ref_kind_t kinds[6] = '{REF_DATA, REF_STR_SRC, REF_STACK, REF_BASE_PTR, REF_STR_DEST,
         REF_FETCH};
      logic [15:0] segs[6] = '{16'h1234, 16'h1234, 16'h2345, 16'h2345, 16'h3456, 16'hFFFF};
      go(REF_FETCH, 16'hFFFF, 20'h0_FFEF);
      ld(2'h1, 16'h1234, 0);
      ld(2'h2, 16'h2345, 0);
      ld(2'h3, 16'h3456, 0);
      chk({4'h0, es}, 20'h0_3456);
      for (int i = 0; i < 6; i++) begin
         go(kinds[i], 16'h0010, {segs[i], 4'h0} + 20'h0_0010);
      end
   endtask : t_segments
   // I/O forms: zero-extended byte, full pointer as word port, then memory again
   task automatic t_io();
      ld(2'h0, 16'hABCD, 1);
      imm = 8'hA5;
      go(REF_IO_IMM, 16'hFFFF, 20'h0_00A5);
      chk({19'h0_0000, last_io}, 20'h0_0001);
      chk({18'h0_0000, ioc, iow_q}, 20'h0_0002);
      iow = 1;
      go(REF_IO_PTR, 16'h0000, 20'h0_ABCD);
      chk({18'h0_0000, ioc, iow_q}, 20'h0_0003);
      iow = 0;
      go(REF_DATA, 16'h0000, 20'h1_2340);
      chk({17'h0_0000, last_io, ioc, iow_q}, 20'h0_0000);
   endtask : t_io
   // code segment load, then a fetch through it
   task automatic t_code_seg();
      ld(2'h0, 16'h8000, 0);
      chk({4'h0, cs}, 20'h0_8000);
      go(REF_FETCH, 16'h0123, 20'h8_0123);
   endtask : t_code_seg
   // mid-run reset: registers and address back to reset values, requests taken again
   task automatic t_reset();
      @(posedge clk) #1;
      rst = 1;
      repeat (2) @(posedge clk);
      #1;
      rst = 0;
      chk({4'h0, cs}, 20'h0_FFFF);
      chk({4'h0, ds | ss | es | pp}, 20'h0_0000);
      chk(addr, 20'h0_0000);
      chk({18'h0_0000, vld, ioc}, 20'h0_0000);
      go(REF_FETCH, 16'h0020, 20'h0_0010);
   endtask : t_reset
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst = 0;
      chk({4'h0, cs}, 20'h0_FFFF);
      chk({4'h0, ds | ss | es | pp}, 20'h0_0000);
      t_segments();
      t_io();
      t_code_seg();
      t_reset();
      give_verdict();
   end
   // watchdog: whole run is under 100 cycles, so this is ample
   initial begin
      #20000;
      bad_count++;
      give_verdict();
   end
endmodule : segmented_address_generator_bench
bind seg_addr_gen seg_addr_gen_monitor mon_u (.*);
`default_nettype wire

// >>> verilog/phys_addr_adder.sv
/*
 * Combinational physical address former: segment * 16 + offset.
 * Assumes a caller that registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "seg_addr_regs.svh"
module phys_addr_adder (
   // operands
   input  wire logic [`SEG_W-1:0]  i_seg,
   input  wire logic [`OFS_W-1:0]  i_ofs,
   // result
   output logic      [`PHYS_W-1:0] o_phys
);
   // ==========================================================
   // sum is formed at 20 bits so the top carry falls away
   always_comb begin
      o_phys = {i_seg, {`SEG_SHIFT{1'b0}}}
               + {{(`PHYS_W-`OFS_W){1'b0}}, i_ofs};
   end
endmodule : phys_addr_adder
`default_nettype wire

// >>> verilog/seg_addr_gen.sv
/*
 * Segmented address generator of the 16-bit core: holds the four
 * segment registers and the port pointer, picks the implied segment
 * and forms memory or I/O addresses one cycle after a request.
 *
 * Timing: a request taken on one rising edge shows its address and a
 * one-cycle valid strobe after that edge; the address and the io flags
 * then stand until the next request. Requests may come every cycle.
 * A segment or port pointer load taken on the same edge as a request
 * is not seen by that request; it serves the next one.
 *
 * Memory addresses are segment times sixteen plus offset, kept to
 * twenty bits so that a carry out of the top bit is lost. I/O
 * addresses are sixteen bits, placed in the low part of the bus.
 *
 * Assumes the instruction sequencer on the same clock drives requests
 * and register loads; no back-pressure exists, so every request is
 * answered, and no input needs synchronising.
 */
`timescale 1ns/1ps
`default_nettype none
`include "seg_addr_regs.svh"
module seg_addr_gen
   import seg_addr_pkg::*;
(
   // clock and reset
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_sys_rst,
   // segment and pointer loads
   input  wire logic                     i_seg_load,
   input  wire logic [1:0]               i_seg_sel,
   input  wire logic [`SEG_W-1:0]        i_seg_value,
   input  wire logic                     i_port_ptr_load,
   input  wire logic [`PORT_W-1:0]       i_port_ptr_value,
   // address request
   input  wire logic                     i_req,
   input  wire seg_addr_pkg::ref_kind_t  i_ref_kind,
   input  wire logic [`OFS_W-1:0]        i_offset,
   input  wire logic [`IMM_PORT_W-1:0]   i_port_imm,
   input  wire logic                     i_io_word,
   // address out to memory and I/O bus
   output logic [`PHYS_W-1:0]            o_addr,
   output logic                          o_addr_valid,
   output logic                          o_io_cycle,
   output logic                          o_io_word,
   // segment and pointer contents, for saves and debug
   output logic [`SEG_W-1:0]             o_code_segment,
   output logic [`SEG_W-1:0]             o_data_segment_register,
   output logic [`SEG_W-1:0]             o_stack_segment,
   output logic [`SEG_W-1:0]             o_extra_segment_register,
   output logic [`PORT_W-1:0]            o_port_pointer_register
);
   import seg_addr_pkg::*;

   sag_state_t         state;
   sag_state_t         next_state;
   logic [`SEG_W-1:0]  chosen_seg;
   logic [`PHYS_W-1:0] mem_addr;
   logic [`PHYS_W-1:0] io_addr;
   logic               req_is_io;

   // ==========================================================
   // implied segment choice: no segment field in the encoding
   function automatic logic [`SEG_W-1:0] pick_seg(input ref_kind_t k,
                                                  input sag_state_t s);
      logic [`SEG_W-1:0] r;
      r = s.data_seg;
      unique case (k)
         REF_FETCH:              r = s.code_seg;
         REF_STACK, REF_BASE_PTR: r = s.stack_seg;
         REF_STR_DEST:           r = s.extra_seg;
         default:                r = s.data_seg;
      endcase
      return r;
   endfunction : pick_seg

   // ==========================================================
   // zero-extended short port, high byte forced low
   function automatic logic [`PORT_W-1:0] short_port(input logic [`IMM_PORT_W-1:0] p);
      return {{(`PORT_W-`IMM_PORT_W){1'b0}}, p};
   endfunction : short_port

   // ==========================================================
   // io kinds address the separate port space, never memory
   function automatic logic is_io_ref(input ref_kind_t k);
      logic r;
      r = 1'b0;
      unique case (k)
         REF_IO_IMM, REF_IO_PTR: r = 1'b1;
         default:                r = 1'b0;              // codes 8 to 15 too
      endcase
      return r;
   endfunction : is_io_ref

   // ==========================================================
   // port number on the address bus; top nibble always zero
   function automatic logic [`PHYS_W-1:0] io_bus_addr(
      input ref_kind_t              k,
      input logic [`PORT_W-1:0]     ptr,
      input logic [`IMM_PORT_W-1:0] imm
   );
      logic [`PORT_W-1:0] port;
      // full pointer or widened byte, nothing from a segment
      port = (k == REF_IO_PTR) ? ptr : short_port(imm);
      return {{(`PHYS_W-`PORT_W){1'b0}}, port};
   endfunction : io_bus_addr

   // ==========================================================
   // one of four segment registers takes the load value
   function automatic sag_state_t write_seg(
      input sag_state_t         s,
      input logic [1:0]         sel,
      input logic [`SEG_W-1:0]  v
   );
      sag_state_t r;
      r = s;
      unique case (sel)
         `SEGSEL_CODE:  r.code_seg  = v;
         `SEGSEL_DATA:  r.data_seg  = v;
         `SEGSEL_STACK: r.stack_seg = v;
         `SEGSEL_EXTRA: r.extra_seg = v;
      endcase
      return r;
   endfunction : write_seg

   // ==========================================================
   // memory cycle: formed address, io flags cleared
   function automatic sag_state_t take_mem(
      input sag_state_t         s,
      input logic [`PHYS_W-1:0] a
   );
      sag_state_t r;
      r            = s;
      r.addr_valid = 1'b1;
      r.io_cycle   = 1'b0;
      r.io_word    = 1'b0;
      r.cyc        = CYC_MEM;
      r.addr       = a;
      return r;
   endfunction : take_mem

   // ==========================================================
   // io cycle: port address, width flag copied from the request
   function automatic sag_state_t take_io(
      input sag_state_t         s,
      input logic [`PHYS_W-1:0] a,
      input logic               word
   );
      sag_state_t r;
      r            = s;
      r.addr_valid = 1'b1;
      r.io_cycle   = 1'b1;
      r.io_word    = word;
      r.cyc        = CYC_IO;
      r.addr       = a;
      return r;
   endfunction : take_io

   // ==========================================================
   // request decode, read from the registers before they move
   assign req_is_io  = is_io_ref(i_ref_kind);
   assign chosen_seg = pick_seg(i_ref_kind, state);
   assign io_addr    = io_bus_addr(i_ref_kind, state.port_ptr, i_port_imm);

   phys_addr_adder u_adder (
      .i_seg  (chosen_seg),
      .i_ofs  (i_offset),
      .o_phys (mem_addr)
   );

   // ==========================================================
   // next-state logic
   always_comb begin
      next_state = state;
      next_state.addr_valid = 1'b0;
      next_state.cyc        = CYC_IDLE;
      // loads land before the next request reads them
      if (i_seg_load) begin
         next_state = write_seg(next_state, i_seg_sel, i_seg_value);
      end
      if (i_port_ptr_load) begin
         next_state.port_ptr = i_port_ptr_value;
      end
      // request uses the old registers, so a same-cycle load waits a cycle
      if (i_req && req_is_io) begin
         next_state = take_io(next_state, io_addr, i_io_word);
      end else if (i_req) begin
         next_state = take_mem(next_state, mem_addr);
      end
   end

   // ==========================================================
   // state register; code segment resets high like a classic core
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state.code_seg   <= `CODE_SEG_RST;
         state.data_seg   <= `SEG_RST;
         state.stack_seg  <= `SEG_RST;
         state.extra_seg  <= `SEG_RST;
         state.port_ptr   <= `PORT_RST;
         state.addr       <= `PHYS_RST;
         state.addr_valid <= 1'b0;
         state.io_cycle   <= 1'b0;
         state.io_word    <= 1'b0;
         state.cyc        <= CYC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // bus side, straight from the state register
   assign o_addr                   = state.addr;
   assign o_addr_valid             = state.addr_valid;
   assign o_io_cycle               = state.io_cycle;
   assign o_io_word                = state.io_word;

   // ==========================================================
   // register contents for saves and debug
   assign o_code_segment           = state.code_seg;
   assign o_data_segment_register  = state.data_seg;
   assign o_stack_segment          = state.stack_seg;
   assign o_extra_segment_register = state.extra_seg;
   assign o_port_pointer_register  = state.port_ptr;
endmodule : seg_addr_gen
`default_nettype wire

// >>> verilog/seg_addr_pkg.sv
/*
 * Types for the segmented address generator.
 * Assumes seg_addr_regs.svh is on the include path.
 */
`default_nettype none
`include "seg_addr_regs.svh"
package seg_addr_pkg;
   // ==========================================================
   // kind of reference presented by the sequencer
   typedef enum logic [3:0] {
      REF_FETCH     = 4'h0,  // opcode or immediate byte
      REF_DATA      = 4'h1,  // ordinary data operand
      REF_STACK     = 4'h2,  // push or pop
      REF_BASE_PTR  = 4'h3,  // offset built with base pointer
      REF_STR_DEST  = 4'h4,  // string op, destination index
      REF_STR_SRC   = 4'h5,  // string op, source index
      REF_IO_IMM    = 4'h6,  // port in instruction byte
      REF_IO_PTR    = 4'h7   // port in port pointer register
   } ref_kind_t;

   // output cycle kind
   typedef enum logic [2:0] {
      CYC_IDLE = 3'b001,
      CYC_MEM  = 3'b010,
      CYC_IO   = 3'b100
   } cyc_kind_t;

   typedef struct packed {
      logic [`SEG_W-1:0]  code_seg;
      logic [`SEG_W-1:0]  data_seg;
      logic [`SEG_W-1:0]  stack_seg;
      logic [`SEG_W-1:0]  extra_seg;
      logic [`PORT_W-1:0] port_ptr;
      logic [`PHYS_W-1:0] addr;
      logic               addr_valid;
      logic               io_cycle;
      logic               io_word;
      cyc_kind_t          cyc;
   } sag_state_t;
endpackage : seg_addr_pkg
`default_nettype wire

// >>> verilog/seg_addr_regs.svh
/*
 * Constants for the segmented address generator: widths, reset values
 * and segment register load selectors.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SEG_ADDR_REGS_SVH
`define SEG_ADDR_REGS_SVH
// Summary of operation
// - physical address is segment shifted left four bits plus offset, 20 bits wide.
// - each segment is a linear run of 65536 bytes reached by a 16-bit offset.
// - four 16-bit segment registers (code, data, stack, extra) supply every segment value.
// - the segment register is chosen implicitly from the kind of reference.
// - instruction fetches, immediates included, use the code segment.
// - ordinary data references use the data segment by default.
// - stack pushes, pops and base-pointer-relative references use the stack segment.
// - string references indexed by the destination index use the extra segment.
// - a separate I/O space of 65536 byte ports or 32768 word ports is used by I/O ops only.
// - an I/O port address comes from an 8-bit immediate or the 16-bit port pointer.
// - an 8-bit port address is zero-extended, bits 15 to 8 driven low.

// ==========================================================
// widths
`define SEG_W        16
`define OFS_W        16
`define PHYS_W       20
`define SEG_SHIFT    4
`define PORT_W       16
`define IMM_PORT_W   8

// ==========================================================
// reset values
`define CODE_SEG_RST 16'hFFFF
`define SEG_RST      16'h0000
`define PORT_RST     16'h0000
`define PHYS_RST     20'h0_0000

// ==========================================================
// segment register load selectors
`define SEGSEL_CODE  2'h0
`define SEGSEL_DATA  2'h1
`define SEGSEL_STACK 2'h2
`define SEGSEL_EXTRA 2'h3
`endif
